// *** core/erb_mem.sv ***
// Storage array with two write ports, lane masks and flow-through reads
// Assumes registered address, mask and data arrive over the bundle
`timescale 1ns/1ns
module erb_mem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 36,
  parameter int LANE = 9,
  parameter int LANES = 4,
  parameter bit INIT_EN = 1'b1,
  parameter logic [WIDTH-1:0] INIT_WORD = '0
) (
  input wire logic core_clk, // Core clock
  input wire logic rst_b, // Reset, read by checks only
  erb_mem_if.mem bus // Array side of both ports
);
  localparam int NP = erb_pkg::NUM_PORTS;

  // Stored words, preloaded or left undefined
  logic [WIDTH-1:0] mem [DEPTH] = '{default: INIT_EN ? INIT_WORD : 'x};
  logic [LANE-1:0] keep_lane;

  // Lane-masked writes, port B last
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < NP; p++) begin
      for (int l = 0; l < LANES; l++) begin
        if (bus.we[p] && bus.be[p][l]) begin
          mem[bus.addr[p]][l*LANE +: LANE] <= bus.din[p][l*LANE +: LANE];
        end
      end
    end
  end

  // Flow-through reads at the registered address
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      bus.rdata[p] = mem[bus.addr[p]];
    end
  end

  // Old lane content for the keep check
  always_ff @(posedge core_clk) begin
    keep_lane <= mem[bus.addr[0]][LANE-1:0];
  end

  chk_lane_written: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.we[0] && bus.be[0][0] && !bus.we[1]
    |=> mem[$past(bus.addr[0])][LANE-1:0] == $past(bus.din[0][LANE-1:0]))
    else $error("Enabled lane not written");
  chk_lane_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.we[0] && !bus.be[0][0] && !bus.we[1]
    |=> mem[$past(bus.addr[0])][LANE-1:0] == keep_lane)
    else $error("Masked lane changed");
endmodule

// *** core/erb_mem_if.sv ***
// Array-side port bundle between the control logic and the storage array
// Assumes both ends run on the core clock
`timescale 1ns/1ns
interface erb_mem_if #(
  parameter int AW = 7,
  parameter int WIDTH = 36,
  parameter int LANES = 4
);
  logic [erb_pkg::NUM_PORTS-1:0] we;
  logic [erb_pkg::NUM_PORTS-1:0][AW-1:0] addr;
  logic [erb_pkg::NUM_PORTS-1:0][LANES-1:0] be;
  logic [erb_pkg::NUM_PORTS-1:0][WIDTH-1:0] din;
  logic [erb_pkg::NUM_PORTS-1:0][WIDTH-1:0] rdata;
  modport ctl (output we, addr, be, din, input rdata);
  modport mem (input we, addr, be, din, output rdata);
endinterface

// *** core/erb_pkg.sv ***
// Shared constants, types and shape checks for the embedded RAM block
// Assumes fabric logic and the block share one core clock
package erb_pkg;
  // Block sizes and usable modes
  typedef enum logic [1:0] {SIZE_SMALL, SIZE_MEDIUM, SIZE_LARGE} erb_size_t;
  typedef enum logic [2:0] {
    MODE_SINGLE, MODE_SDP, MODE_TDP, MODE_ROM, MODE_FIFO, MODE_SHIFT
  } erb_mode_t;
  // Capacity in bits, parity bits included
  localparam int CAP_SMALL = 576;
  localparam int CAP_MEDIUM = 4608;
  localparam int CAP_LARGE = 589824;
  // Word width limits per size
  localparam int MAXW_SMALL = 18;
  localparam int MAXW_MEDIUM = 36;
  localparam int MAXW_LARGE = 144;
  localparam int MINW_LARGE = 8;
  // Lane widths without and with parity
  localparam int LANE_PLAIN = 8;
  localparam int LANE_PARITY = 9;
  // Register groups, one clock select bit each
  localparam int GRP_EN = 0;
  localparam int GRP_ADDR = 1;
  localparam int GRP_BE = 2;
  localparam int GRP_DIN = 3;
  localparam int GRP_OUT = 4;
  localparam int NUM_GRP = 5;
  // Bits of the per-port clear target, then port count and port indices
  localparam int CLR_IN = 0;
  localparam int CLR_OUT = 1;
  localparam int NUM_PORTS = 2;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;

  function automatic bit is_pow2(int v);
    return v > 0 && (v & (v - 1)) == 0;
  endfunction

  // Legal depth by width shapes of each size
  function automatic bit cfg_ok(erb_size_t s, int w, int d);
    int cap;
    int maxw;
    int minw;
    cap = (s == SIZE_SMALL) ? CAP_SMALL : (s == SIZE_MEDIUM) ? CAP_MEDIUM : CAP_LARGE;
    maxw = (s == SIZE_SMALL) ? MAXW_SMALL : (s == SIZE_MEDIUM) ? MAXW_MEDIUM : MAXW_LARGE;
    minw = (s == SIZE_LARGE) ? MINW_LARGE : 1;
    if (w < minw || w > maxw || !is_pow2(d)) return 1'b0;
    if (w % LANE_PARITY == 0) return is_pow2(w / LANE_PARITY) && d * w == cap;
    return is_pow2(w) && d * w * LANE_PARITY == cap * LANE_PLAIN;
  endfunction

  // Byte lane width for a word width
  function automatic int lane_of(int w);
    return (w % LANE_PARITY == 0) ? LANE_PARITY : (w < LANE_PLAIN) ? w : LANE_PLAIN;
  endfunction
endpackage

// *** core/erb_ram_block.sv ***
// Configurable embedded RAM block: small, medium or large size
// Assumes fabric logic on core_clk drives ports and the two block clock ticks
`timescale 1ns/1ns
module erb_ram_block #(
  parameter erb_pkg::erb_size_t SIZE = erb_pkg::SIZE_MEDIUM,
  parameter erb_pkg::erb_mode_t MODE = erb_pkg::MODE_TDP,
  parameter int WIDTH = 36,
  parameter int DEPTH = 128,
  parameter logic [4:0] CLK_SEL_A = 5'h00,
  parameter logic [4:0] CLK_SEL_B = 5'h00,
  parameter bit OUT_REG_A = 1'b1,
  parameter bit OUT_REG_B = 1'b1,
  parameter logic [1:0] CLR_A = 2'h2,
  parameter logic [1:0] CLR_B = 2'h2,
  parameter logic [WIDTH-1:0] INIT_WORD = '0
) (
  input wire logic core_clk, // Core clock
  input wire logic rst_b, // Synchronous reset
  input wire logic clk0_tick, // Block clock 0 edge
  input wire logic clk1_tick, // Block clock 1 edge
  input wire logic clocken_a, // Port A clock enable
  input wire logic addr_ena_a, // Port A address enable
  input wire logic renwe_a, // Port A write, else read
  input wire logic aclr_a, // Port A clear
  input wire logic [$clog2(DEPTH)-1:0] addr_a, // Port A address
  input wire logic [WIDTH/erb_pkg::lane_of(WIDTH)-1:0] byteena_a, // Port A lanes
  input wire logic [WIDTH-1:0] din_a, // Port A write data
  output logic [WIDTH-1:0] dout_a, // Port A read data
  input wire logic clocken_b, // Port B clock enable
  input wire logic addr_ena_b, // Port B address enable
  input wire logic renwe_b, // Port B write, else read
  input wire logic aclr_b, // Port B clear
  input wire logic [$clog2(DEPTH)-1:0] addr_b, // Port B address
  input wire logic [WIDTH/erb_pkg::lane_of(WIDTH)-1:0] byteena_b, // Port B lanes
  input wire logic [WIDTH-1:0] din_b, // Port B write data
  output logic [WIDTH-1:0] dout_b, // Port B read data
  output logic fifo_full, // Queue full
  output logic fifo_empty // Queue empty
);
  localparam int NP = erb_pkg::NUM_PORTS;
  localparam int AW = $clog2(DEPTH);
  localparam int LANE = erb_pkg::lane_of(WIDTH);
  localparam int LANES = WIDTH / LANE;
  localparam int PA = erb_pkg::PORT_A;
  localparam int PB = erb_pkg::PORT_B;
  localparam bit PTR_MODE = MODE == erb_pkg::MODE_FIFO || MODE == erb_pkg::MODE_SHIFT;
  localparam bit IS_FIFO = MODE == erb_pkg::MODE_FIFO;
  // Write permission per port for the chosen mode
  localparam logic [1:0] WR_ALLOW = {MODE == erb_pkg::MODE_TDP, MODE != erb_pkg::MODE_ROM};

  // Shape, mode and write clock checks at elaboration
  if (!erb_pkg::cfg_ok(SIZE, WIDTH, DEPTH)) begin : g_bad_shape
    $error("Depth and width not a legal shape for this size");
  end
  if (SIZE == erb_pkg::SIZE_SMALL && MODE == erb_pkg::MODE_TDP) begin : g_bad_small
    $error("Small size has no true dual-port mode");
  end
  if (SIZE == erb_pkg::SIZE_LARGE && (MODE == erb_pkg::MODE_ROM
      || MODE == erb_pkg::MODE_SHIFT)) begin : g_bad_large
    $error("Large size has no preload and no shift mode");
  end
  if (SIZE == erb_pkg::SIZE_SMALL && !(CLK_SEL_A == 5'h00 || CLK_SEL_A == 5'h1F
      || CLK_SEL_A == 5'h10 || CLK_SEL_A == 5'h0F)) begin : g_bad_wclk
    $error("Small size write group must share one clock");
  end

  // One port's register set
  typedef struct packed {
    logic op_wr;
    logic wr_go;
    logic [AW-1:0] addr;
    logic [LANES-1:0] be;
    logic [WIDTH-1:0] din;
    logic [WIDTH-1:0] dout;
  } erb_port_t;

  // Whole block state
  typedef struct packed {
    erb_port_t [NP-1:0] port;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic full;
    logic empty;
  } erb_state_t;

  localparam erb_state_t RST_STATE = '{port: '0, wr_ptr: '0, rd_ptr: '0,
    count: '0, full: 1'b0, empty: 1'b1};

  erb_state_t state;
  erb_state_t next_state;
  logic [1:0] tick;
  logic [NP-1:0] clocken;
  logic [NP-1:0] addr_ena;
  logic [NP-1:0] renwe;
  logic [NP-1:0] aclr;
  logic [NP-1:0][AW-1:0] in_addr;
  logic [NP-1:0][LANES-1:0] in_be;
  logic [NP-1:0][WIDTH-1:0] in_din;
  logic [NP-1:0][4:0] sel;
  logic [NP-1:0][1:0] clr_tgt;
  logic [NP-1:0] out_reg;

  erb_mem_if #(.AW(AW), .WIDTH(WIDTH), .LANES(LANES)) mif ();

  // Gather both ports into arrays
  assign tick = {clk1_tick, clk0_tick};
  assign clocken = {clocken_b, clocken_a};
  assign addr_ena = {addr_ena_b, addr_ena_a};
  assign renwe = {renwe_b, renwe_a};
  assign aclr = {aclr_b, aclr_a};
  assign in_addr = {addr_b, addr_a};
  assign in_be = {byteena_b, byteena_a};
  assign in_din = {din_b, din_a};
  assign sel = {CLK_SEL_B, CLK_SEL_A};
  assign clr_tgt = {CLR_B, CLR_A};
  assign out_reg = {OUT_REG_B, OUT_REG_A};

  // Next state of registers, pointers and queue flags
  always_comb begin
    logic [NP-1:0][erb_pkg::NUM_GRP-1:0] cap;
    logic [NP-1:0] accept;
    logic push;
    logic pop;
    cap = '0;
    accept = '0;
    push = 1'b0;
    pop = 1'b0;
    next_state = state;
    for (int p = 0; p < NP; p++) begin
      // Each group follows its chosen block clock
      for (int g = 0; g < erb_pkg::NUM_GRP; g++) begin
        cap[p][g] = tick[sel[p][g]] & clocken[p];
      end
      // Writes only where the mode lets the port write
      accept[p] = cap[p][erb_pkg::GRP_EN] & renwe[p] & WR_ALLOW[p];
    end
    // Queue refuses a push when full
    if (IS_FIFO && state.full) begin
      accept[PA] = 1'b0;
    end
    push = accept[PA];
    pop = IS_FIFO && cap[PB][erb_pkg::GRP_EN] && renwe[PB] && !state.empty;
    for (int p = 0; p < NP; p++) begin
      next_state.port[p].wr_go = 1'b0;
      // Input registers: request, address, lanes, data
      if (cap[p][erb_pkg::GRP_EN]) begin
        next_state.port[p].op_wr = accept[p];
        next_state.port[p].wr_go = accept[p];
      end
      if (PTR_MODE) begin
        if (cap[p][erb_pkg::GRP_EN]) begin
          next_state.port[p].addr = (p == PB && IS_FIFO) ? state.rd_ptr : state.wr_ptr;
        end
      end else if (cap[p][erb_pkg::GRP_ADDR] && addr_ena[p]) begin
        next_state.port[p].addr = in_addr[p];
      end
      if (cap[p][erb_pkg::GRP_BE]) begin
        next_state.port[p].be = in_be[p];
      end
      if (cap[p][erb_pkg::GRP_DIN]) begin
        next_state.port[p].din = in_din[p];
      end
      // Output register, or flow-through when bypassed
      if (!state.port[p].op_wr && (!out_reg[p] || cap[p][erb_pkg::GRP_OUT])) begin
        next_state.port[p].dout = mif.rdata[p];
      end
      // Clears act without waiting for a block clock
      if (aclr[p] && clr_tgt[p][erb_pkg::CLR_IN]) begin
        next_state.port[p].op_wr = 1'b0;
        next_state.port[p].wr_go = 1'b0;
        next_state.port[p].addr = '0;
        next_state.port[p].be = '0;
        next_state.port[p].din = '0;
      end
      if (aclr[p] && clr_tgt[p][erb_pkg::CLR_OUT]) begin
        next_state.port[p].dout = '0;
      end
    end
    // Pointers for queue and delay-line use
    if (push) begin
      next_state.wr_ptr = state.wr_ptr + AW'(1);
    end
    if (pop) begin
      next_state.rd_ptr = state.rd_ptr + AW'(1);
    end
    if (IS_FIFO) begin
      next_state.count = state.count + (AW+1)'(push) - (AW+1)'(pop);
    end
    next_state.full = next_state.count == (AW+1)'(DEPTH);
    next_state.empty = next_state.count == '0;
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= RST_STATE;
    end else begin
      state <= next_state;
    end
  end

  // Array drive from the registered inputs; A is the right units, B the left
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      mif.we[p] = state.port[p].wr_go;
      mif.addr[p] = state.port[p].addr;
      mif.be[p] = state.port[p].be;
      mif.din[p] = state.port[p].din;
    end
  end

  erb_mem #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH),
    .LANE(LANE),
    .LANES(LANES),
    .INIT_EN(SIZE != erb_pkg::SIZE_LARGE),
    .INIT_WORD(INIT_WORD)
  ) u_mem (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .bus(mif.mem)
  );

  // Outputs straight from the state register
  assign dout_a = state.port[PA].dout;
  assign dout_b = state.port[PB].dout;
  assign fifo_full = state.full;
  assign fifo_empty = state.empty;

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Clear, output register, write and address checks
  chk_out_clear_now: assert property (
    aclr_a && CLR_A[erb_pkg::CLR_OUT] |=> dout_a == '0)
    else $error("Output clear not seen at once");
  chk_in_clear_regs: assert property (
    aclr_b && CLR_B[erb_pkg::CLR_IN]
    |=> state.port[PB].addr == '0 && !mif.we[PB] && state.port[PB].din == '0)
    else $error("Input clear left state behind");
  chk_out_reg_hold: assert property (
    OUT_REG_A && !(tick[CLK_SEL_A[erb_pkg::GRP_OUT]] && clocken_a)
    && !(aclr_a && CLR_A[erb_pkg::CLR_OUT]) |=> $stable(dout_a))
    else $error("Registered output moved without its clock");
  chk_bypass_follow: assert property (
    !OUT_REG_B && !state.port[PB].op_wr && !(aclr_b && CLR_B[erb_pkg::CLR_OUT])
    |=> dout_b == $past(mif.rdata[PB]))
    else $error("Bypassed output not following array");
  chk_write_registered: assert property (
    mif.we[PA] |-> $past(tick[CLK_SEL_A[erb_pkg::GRP_EN]] && clocken_a && renwe_a))
    else $error("Write without a registered request");
  chk_read_port_only: assert property (
    MODE != erb_pkg::MODE_TDP |-> !mif.we[PB])
    else $error("Port B wrote outside true dual-port");
  chk_rom_no_write: assert property (
    MODE == erb_pkg::MODE_ROM |-> mif.we == '0)
    else $error("Write in ROM mode");
  chk_addr_ena_hold: assert property (
    !PTR_MODE && !addr_ena_a && !(aclr_a && CLR_A[erb_pkg::CLR_IN])
    |=> $stable(state.port[PA].addr))
    else $error("Address moved while its enable was low");
  chk_b_addr_clock: assert property (
    !PTR_MODE && tick[CLK_SEL_B[erb_pkg::GRP_ADDR]] && clocken_b && addr_ena_b
    && !(aclr_b && CLR_B[erb_pkg::CLR_IN]) |=> state.port[PB].addr == $past(addr_b))
    else $error("Port B address not taken on its clock");
  chk_fifo_no_overrun: assert property (
    IS_FIFO && fifo_full |=> !mif.we[PA])
    else $error("Push accepted while full");

  // Port A groups take their inputs on their own block clock
  chk_a_req_clock: assert property (
    !IS_FIFO && tick[CLK_SEL_A[erb_pkg::GRP_EN]] && clocken_a
    && !(aclr_a && CLR_A[erb_pkg::CLR_IN])
    |=> state.port[PA].op_wr == ($past(renwe_a) && WR_ALLOW[PA]))
    else $error("Port A request not taken on its clock");
  chk_a_addr_clock: assert property (
    !PTR_MODE && tick[CLK_SEL_A[erb_pkg::GRP_ADDR]] && clocken_a && addr_ena_a
    && !(aclr_a && CLR_A[erb_pkg::CLR_IN]) |=> state.port[PA].addr == $past(addr_a))
    else $error("Port A address not taken on its clock");
  chk_a_lanes_clock: assert property (
    tick[CLK_SEL_A[erb_pkg::GRP_BE]] && clocken_a && !(aclr_a && CLR_A[erb_pkg::CLR_IN])
    |=> state.port[PA].be == $past(byteena_a))
    else $error("Port A lanes not taken on their clock");
  chk_a_data_clock: assert property (
    tick[CLK_SEL_A[erb_pkg::GRP_DIN]] && clocken_a && !(aclr_a && CLR_A[erb_pkg::CLR_IN])
    |=> state.port[PA].din == $past(din_a))
    else $error("Port A data not taken on its clock");
  // Port B groups, same form
  chk_b_req_clock: assert property (
    tick[CLK_SEL_B[erb_pkg::GRP_EN]] && clocken_b
    && !(aclr_b && CLR_B[erb_pkg::CLR_IN])
    |=> state.port[PB].op_wr == ($past(renwe_b) && WR_ALLOW[PB]))
    else $error("Port B request not taken on its clock");
  chk_b_lanes_clock: assert property (
    tick[CLK_SEL_B[erb_pkg::GRP_BE]] && clocken_b && !(aclr_b && CLR_B[erb_pkg::CLR_IN])
    |=> state.port[PB].be == $past(byteena_b))
    else $error("Port B lanes not taken on their clock");
  chk_b_data_clock: assert property (
    tick[CLK_SEL_B[erb_pkg::GRP_DIN]] && clocken_b && !(aclr_b && CLR_B[erb_pkg::CLR_IN])
    |=> state.port[PB].din == $past(din_b))
    else $error("Port B data not taken on its clock");
  // Output register loads on its clock, and only for a stored read
  chk_out_reg_load: assert property (
    OUT_REG_A && tick[CLK_SEL_A[erb_pkg::GRP_OUT]] && clocken_a && !state.port[PA].op_wr
    && !(aclr_a && CLR_A[erb_pkg::CLR_OUT]) |=> dout_a == $past(mif.rdata[PA]))
    else $error("Registered output missed its load");
  chk_write_holds_out: assert property (
    state.port[PA].op_wr && !(aclr_a && CLR_A[erb_pkg::CLR_OUT]) |=> $stable(dout_a))
    else $error("Output moved while a write was stored");
  // Writes need a registered request and an open clock enable; queue full and empty never both set
  chk_b_write_registered: assert property (
    mif.we[PB] |-> $past(tick[CLK_SEL_B[erb_pkg::GRP_EN]] && clocken_b && renwe_b))
    else $error("Port B write without a registered request");
  chk_a_gate_write: assert property (
    !clocken_a |=> !mif.we[PA])
    else $error("Port A wrote with its clock enable low");
  chk_b_gate_write: assert property (
    !clocken_b |=> !mif.we[PB])
    else $error("Port B wrote with its clock enable low");
  chk_flags_exclusive: assert property (
    !(fifo_full && fifo_empty))
    else $error("Queue full and empty at once");

  cov_write_then_read: cover property (mif.we[PA] ##1 !state.port[PA].op_wr);
  cov_fifo_full: cover property (IS_FIFO && fifo_full);
  cov_out_cleared: cover property (aclr_a ##1 dout_a == '0);
  cov_addr_held: cover property (!addr_ena_a && clocken_a ##1 !addr_ena_a);
  cov_in_cleared: cover property (aclr_b ##1 !aclr_b);
endmodule

// *** dv/erb_fab_clk.sv ***
// Fabric-side clock source that makes the two block clock ticks
// Assumes the block samples the ticks on core_clk with no synchronizer
`timescale 1ns/1ns
module erb_fab_clk (
  input wire logic core_clk, // Core clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic slow, // Stretch tick spacing
  output logic clk0_tick, // Block clock 0 edge
  output logic clk1_tick // Block clock 1 edge
);
  logic [1:0] phase;

  // Tick period counter, two cycles when fast, three when slow
  always_ff @(posedge core_clk) begin
    if (!rst_b || phase == (slow ? 2'h2 : 2'h1)) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Clocks stand still in reset; clock 0 every cycle when fast
  assign clk0_tick = rst_b && (!slow || phase == 2'h0);
  assign clk1_tick = rst_b && phase == 2'h1; // Clock 1 once a period
endmodule

// *** dv/erb_ram_block_tb_top.sv ***
// Self-checking bench for the medium block in true dual-port mode
// Assumes port A output on clock 1, port B output bypassed, preloaded words
`timescale 1ns/1ns
module erb_ram_block_tb_top;
  localparam logic [35:0] INIT = 36'h9A5C31E7B;
  logic core_clk, rst_b, slow, clk0_tick, clk1_tick;
  logic clocken_a, addr_ena_a, renwe_a, aclr_a, clocken_b, addr_ena_b, renwe_b, aclr_b;
  logic [6:0] addr_a, addr_b, last_aa, last_ab;
  logic [3:0] byteena_a, byteena_b;
  logic [35:0] din_a, din_b, dout_a, dout_b;
  logic fifo_full, fifo_empty;
  logic [35:0] ref_mem [128];
  int errors, checked, cycles;

  erb_fab_clk erb_fab_clk_inst (.core_clk(core_clk), .rst_b(rst_b), .slow(slow),
    .clk0_tick(clk0_tick), .clk1_tick(clk1_tick));

  erb_ram_block #(.SIZE(erb_pkg::SIZE_MEDIUM), .MODE(erb_pkg::MODE_TDP), .WIDTH(36),
    .DEPTH(128), .CLK_SEL_A(5'h10), .CLK_SEL_B(5'h00), .OUT_REG_A(1'b1),
    .OUT_REG_B(1'b0), .CLR_A(2'h2), .CLR_B(2'h1), .INIT_WORD(INIT)) erb_ram_block_inst (
    .core_clk(core_clk), .rst_b(rst_b), .clk0_tick(clk0_tick), .clk1_tick(clk1_tick),
    .clocken_a(clocken_a), .addr_ena_a(addr_ena_a), .renwe_a(renwe_a), .aclr_a(aclr_a),
    .addr_a(addr_a), .byteena_a(byteena_a), .din_a(din_a), .dout_a(dout_a),
    .clocken_b(clocken_b), .addr_ena_b(addr_ena_b), .renwe_b(renwe_b), .aclr_b(aclr_b),
    .addr_b(addr_b), .byteena_b(byteena_b), .din_b(din_b), .dout_b(dout_b),
    .fifo_full(fifo_full), .fifo_empty(fifo_empty));

  // Core clock, 50 ns period
  always #25 core_clk = ~core_clk;

  // Lane merge of a masked write
  function automatic logic [35:0] merge(logic [35:0] old, logic [35:0] nw, logic [3:0] be);
    logic [35:0] r;
    r = old;
    for (int l = 0; l < 4; l++) if (be[l]) r[l*9 +: 9] = nw[l*9 +: 9];
    return r;
  endfunction

  task automatic test_done();
    $display("Counts: %0d compares, %0d mismatches", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Drive both ports, hold for eight edges, then compare the reads
  task automatic go(input logic wa, input logic [6:0] aa, input logic [35:0] da,
                    input logic [3:0] ba, input logic wb, input logic [6:0] ab,
                    input logic [35:0] db, input logic [3:0] bb);
    logic [6:0] ea;
    logic [6:0] eb;
    renwe_a <= wa;
    addr_a <= aa;
    din_a <= da;
    byteena_a <= ba;
    renwe_b <= wb;
    addr_b <= ab;
    din_b <= db;
    byteena_b <= bb;
    repeat (8) @(posedge core_clk);
    #1;
    // Address register keeps its old value without enable or clock enable
    ea = (addr_ena_a && clocken_a) ? aa : last_aa;
    eb = (addr_ena_b && clocken_b) ? ab : last_ab;
    last_aa = ea;
    last_ab = eb;
    if (wa && clocken_a) ref_mem[ea] = merge(ref_mem[ea], da, ba);
    if (wb && clocken_b) ref_mem[eb] = merge(ref_mem[eb], db, bb); // Port B wins
    if (!wa) chk(dout_a, ref_mem[ea]);
    if (!wb) chk(dout_b, ref_mem[eb]);
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    slow = 1'b0;
    {clocken_a, addr_ena_a, renwe_a, aclr_a} = 4'h0;
    {clocken_b, addr_ena_b, renwe_b, aclr_b} = 4'h0;
    {addr_a, addr_b, byteena_a, byteena_b} = 22'h0;
    {din_a, din_b} = 72'h0;
    {last_aa, last_ab} = 14'h0;
    errors = 0;
    checked = 0;
    cycles = 0;
    for (int i = 0; i < 128; i++) ref_mem[i] = INIT;
    void'($urandom(32'hF040));
    repeat (3) @(posedge core_clk);
    #1;
    // Reset values
    chk(dout_a, 36'h0);
    chk({35'h0, fifo_empty}, 36'h1);
    chk({35'h0, fifo_full}, 36'h0);
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    {clocken_a, addr_ena_a, clocken_b, addr_ena_b} <= 4'hF;
    // Untouched words show the preload
    for (int i = 0; i < 4; i++) begin
      go(1'b0, 7'(64 + i * 17), 36'h0, 4'h0, 1'b0, 7'(100 + i), 36'h0, 4'h0);
    end
    // Corner: both ports write one word, partial lanes
    go(1'b1, 7'h03, 36'hFFFFFFFFF, 4'h5, 1'b1, 7'h03, 36'h123456789, 4'h6);
    go(1'b0, 7'h03, 36'h0, 4'h0, 1'b0, 7'h03, 36'h0, 4'h0);
    // Random traffic on both ports, random tick spacing and address enables
    for (int i = 0; i < 120; i++) begin
      slow <= 1'($urandom);
      {addr_ena_a, addr_ena_b} <= (i % 4 == 3) ? 2'($urandom) : 2'h3;
      go(1'($urandom), 7'($urandom % 16), {4'($urandom), 32'($urandom)}, 4'($urandom),
         1'($urandom), 7'($urandom % 16), {4'($urandom), 32'($urandom)},
         4'($urandom));
    end
    slow <= 1'b0;
    {addr_ena_a, addr_ena_b} <= 2'h3;
    // Address enable low keeps the old address
    go(1'b0, 7'h03, 36'h0, 4'h0, 1'b0, 7'h03, 36'h0, 4'h0);
    addr_ena_a <= 1'b0;
    go(1'b0, 7'h07, 36'h0, 4'h0, 1'b0, 7'h07, 36'h0, 4'h0);
    chk(dout_a, ref_mem[3]);
    addr_ena_a <= 1'b1;
    // Clock enable low blocks a write
    clocken_a <= 1'b0;
    go(1'b1, 7'h05, ~ref_mem[5], 4'hF, 1'b0, 7'h05, 36'h0, 4'h0);
    ref_mem[5] = merge(ref_mem[5], ref_mem[5], 4'h0);
    clocken_a <= 1'b1;
    go(1'b0, 7'h05, 36'h0, 4'h0, 1'b0, 7'h05, 36'h0, 4'h0);
    // Output clear on A shows zero one edge later, no tick needed
    go(1'b0, 7'h05, 36'h0, 4'h0, 1'b1, 7'h05, ~ref_mem[0], 4'hF);
    go(1'b0, 7'h05, 36'h0, 4'h0, 1'b0, 7'h05, 36'h0, 4'h0);
    clocken_a <= 1'b0;
    aclr_a <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(dout_a, 36'h0);
    aclr_a <= 1'b0;
    clocken_a <= 1'b1;
    // Input clear on B resets the address, output shows it a cycle later
    clocken_b <= 1'b0;
    aclr_b <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(dout_b, ref_mem[5]);
    aclr_b <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(dout_b, ref_mem[0]);
    last_ab = 7'h00;
    clocken_b <= 1'b1;
    go(1'b0, 7'h05, 36'h0, 4'h0, 1'b0, 7'h00, 36'h0, 4'h0);
    test_done();
  end
endmodule
